// File: common/rmr_defs.svh
`ifndef RMR_DEFS_SVH
`define RMR_DEFS_SVH

// message header layout
`define RMR_HDR_LAST      5'h13
`define RMR_PROTO_MARK    32'h5254_5053
`define RMR_MAJOR_MAX     8'h01
`define RMR_SUBH_LAST     5'h03
`define RMR_CAP           5'h18

// reset values of the receiver context
`define RMR_VERSION_INIT  16'h0102
`define RMR_VENDOR_UNK    16'h0000
`define RMR_PREFIX_UNK    96'h0
`define RMR_TIME_INVALID  64'hffff_ffff_ffff_ffff
`define RMR_ADDR_INVALID  128'h0
`define RMR_PORT_INVALID  32'h0000_0000

// submessage kind codes
`define RMR_ID_PAD        8'h01
`define RMR_ID_ACKNACK    8'h06
`define RMR_ID_HB         8'h07
`define RMR_ID_GAP        8'h08
`define RMR_ID_INFO_TS    8'h09
`define RMR_ID_INFO_SRC   8'h0c
`define RMR_ID_INFO_DST   8'h0e
`define RMR_ID_INFO_REPLY 8'h0f
`define RMR_ID_NACK_FRAG  8'h12
`define RMR_ID_HB_FRAG    8'h13
`define RMR_ID_NOKEY_DATA 8'h14
`define RMR_ID_DATA       8'h15
`define RMR_ID_DATA_FRAG  8'h16
`define RMR_ID_NOKEY_FRAG 8'h17

// least body length of each known kind, in bytes
`define RMR_MIN_NONE      5'h00
`define RMR_MIN_INFO_TS   5'h08
`define RMR_MIN_INFO_SRC  5'h14
`define RMR_MIN_INFO_DST  5'h0c
`define RMR_MIN_INFO_REP  5'h04
`define RMR_MIN_ENTITY    5'h08
`define RMR_MIN_SET       5'h18

// sequence and fragment number sets
`define RMR_SN_UNKNOWN    64'hffff_ffff_0000_0000
`define RMR_SET_BITS_MAX  32'h0000_0100
`define RMR_SN_TOP        64'h7fff_ffff_ffff_ff01

`endif

// File: common/rmr_pkg.sv
package rmr_pkg;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } rmr_in_t;

  typedef struct packed {
    logic [31:0]  kind;
    logic [127:0] addr;
    logic [31:0]  port;
  } rmr_loc_t;

  typedef struct packed {
    logic [15:0] version;
    logic [15:0] vendor;
    logic [95:0] src_prefix;
    logic [95:0] dst_prefix;
    logic        have_ts;
    logic [63:0] ts;
    rmr_loc_t    mc_loc;
  } rmr_ctx_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic       ok;
    logic       little;
    logic       set_unknown;
    logic [7:0] kind;
    logic [7:0] data;
  } rmr_ep_t;

  typedef enum logic [4:0] {
    RMR_IDLE = 5'b00001,
    RMR_HDR  = 5'b00010,
    RMR_SUBH = 5'b00100,
    RMR_BODY = 5'b01000,
    RMR_DROP = 5'b10000
  } rmr_state_t;

endpackage

// File: rtl/rmr_set_check.sv
`include "rmr_defs.svh"

// format check of a sequence or fragment number set element
module rmr_set_check (
  // set element, base already widened to 64 bits
  input  wire logic signed [63:0] base,
  input  wire logic        [31:0] num_bits,
  // verdict
  output logic                    set_ok,
  output logic                    base_unknown
);

  wire logic base_pos;
  wire logic base_room;
  wire logic bits_fit;

  // signed compare over the full width
  assign base_pos  = base >= 64'sh0000_0000_0000_0001; // R11 R12
  // base+255 must not pass the largest sequence number
  assign base_room = base < $signed(`RMR_SN_TOP); // R11
  assign bits_fit  = num_bits <= `RMR_SET_BITS_MAX; // R12 R13
  assign set_ok    = base_pos && base_room && bits_fit; // R12
  assign base_unknown = base == $signed(`RMR_SN_UNKNOWN); // R15

endmodule

// File: rtl/rmr_receiver.sv
`include "rmr_defs.svh"

// How it works
// R1 - message start resets reply locator: transport kind, bad addr, bad port
// R2 - too few bytes left for a submessage header discards the message rest
// R3 - next submessage found by length field; bad length drops message rest
// R4 - submessage ids outside the known kind set are skipped
// R5 - vendor range ids from an unknown vendor are skipped
// R6 - unknown and unused flag bits never cause rejection
// R7 - advance always by the length field, never by kind knowledge
// R8 - known submessage failing checks discards the rest of the message
// R9 - only header and info submessages change receiver context
// R10 - valid entity submessages go to endpoints with the current context
// R11 - sequence numbers are 64-bit signed, compared signed over full width
// R12 - a set is valid only when members lie in base..base+255, base >= 1
// R13 - a set is a base plus a bitmap of at most 256 bits
// R14 - fragment numbers are 32-bit unsigned values
// R15 - the reserved unknown sequence number is recognised
// R16 - reserved unknown vendor id is recognised; others select extensions (none are built in, so vendor range ids are skipped for every vendor)
// R17 - zero length runs to message end; else offset to next header
// R18 - flag bit 0 selects byte order of the submessage's fields
// R19 - a good header loads prefix, version, vendor and clears timestamp flag
// R20 - short header, wrong marker or too high major version is rejected
// R21 - transport brackets each whole message with start and end markers
// R22 - message start clears timestamp flag and sets timestamp invalid
module rmr_receiver (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  // transport byte stream
  input  wire rmr_pkg::rmr_in_t in_byte,
  // local configuration
  input  wire logic [31:0]     transport_kind,
  input  wire logic [95:0]     local_prefix,
  // endpoint stream and context
  output rmr_pkg::rmr_ep_t     ep_out,
  output rmr_pkg::rmr_ctx_t    ctx,
  // message events
  output logic                 msg_done,
  output logic                 msg_drop,
  output logic                 sub_skip
);

  rmr_pkg::rmr_state_t state;
  logic [4:0]  idx;
  logic [4:0]  bcnt;
  logic [15:0] rem;
  logic        zero_len;
  logic [7:0]  sub_id;
  logic [7:0]  sub_flags;
  logic [7:0]  len_lo;
  logic [7:0]  cap [`RMR_CAP];
  // one stage delays each byte a cycle so the last byte can carry its submessage verdict
  logic        p_fwd;
  logic        p_first;
  logic        p_end;
  logic        p_lenbad;
  logic        p_msg_end;
  logic [7:0]  p_data;

  function automatic logic [31:0] get32(input logic [7:0] b0,
      input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
      input logic le);
    get32 = le ? {b3, b2, b1, b0} : {b0, b1, b2, b3};
  endfunction

  function automatic logic [4:0] min_len(input logic [7:0] id);
    case (id)
      `RMR_ID_INFO_TS:    min_len = `RMR_MIN_INFO_TS;
      `RMR_ID_INFO_SRC:   min_len = `RMR_MIN_INFO_SRC;
      `RMR_ID_INFO_DST:   min_len = `RMR_MIN_INFO_DST;
      `RMR_ID_INFO_REPLY: min_len = `RMR_MIN_INFO_REP;
      `RMR_ID_ACKNACK,
      `RMR_ID_NACK_FRAG:  min_len = `RMR_MIN_SET;
      `RMR_ID_PAD:        min_len = `RMR_MIN_NONE;
      default:            min_len = `RMR_MIN_ENTITY;
    endcase
  endfunction

  // stream decode
  wire logic v     = in_byte.valid;
  wire logic sop   = v && in_byte.sop;
  wire logic eop   = v && in_byte.eop;
  wire logic [7:0] d = in_byte.data;
  wire logic st_hdr  = state == rmr_pkg::RMR_HDR;
  wire logic st_subh = state == rmr_pkg::RMR_SUBH;
  wire logic st_body = state == rmr_pkg::RMR_BODY;
  wire logic little  = sub_flags[0]; // R18

  // kind classification; other flag bits are never inspected
  wire logic is_entity = sub_id inside {`RMR_ID_NOKEY_DATA, `RMR_ID_DATA,
                         `RMR_ID_NOKEY_FRAG, `RMR_ID_DATA_FRAG, `RMR_ID_HB,
                         `RMR_ID_ACKNACK, `RMR_ID_GAP, `RMR_ID_HB_FRAG,
                         `RMR_ID_NACK_FRAG}; // R10 R6
  wire logic is_info   = sub_id inside {`RMR_ID_INFO_TS, `RMR_ID_INFO_SRC,
                         `RMR_ID_INFO_DST, `RMR_ID_INFO_REPLY}; // R9
  wire logic is_known  = is_entity || is_info || sub_id == `RMR_ID_PAD; // R4
  wire logic vendor_kind = sub_id[7];
  wire logic vendor_unk  = ctx.vendor == `RMR_VENDOR_UNK; // R16

  // header checks on the twentieth byte
  wire logic hdr_last = st_hdr && v && !sop && idx == `RMR_HDR_LAST;
  wire logic [31:0] mark = {cap[0], cap[1], cap[2], cap[3]};
  wire logic hdr_ok = mark == `RMR_PROTO_MARK &&
                      cap[4] <= `RMR_MAJOR_MAX; // R20
  wire logic hdr_short = st_hdr && eop && !sop && idx != `RMR_HDR_LAST; // R20

  // submessage header and length
  wire logic subh_last = st_subh && v && !sop && idx == `RMR_SUBH_LAST;
  wire logic [15:0] len_now = little ? {d, len_lo} : {len_lo, d}; // R18
  wire logic subh_short = st_subh && eop && !sop &&
                          idx != `RMR_SUBH_LAST; // R2
  wire logic empty_end = subh_last && eop && len_now == 16'h0000; // R17
  wire logic empty_bad = subh_last && eop && len_now != 16'h0000; // R3

  // body end: by the length field, or by message end for zero length
  wire logic body_byte = st_body && v && !sop;
  wire logic body_end  = body_byte &&
                         (eop || (!zero_len && rem == 16'h0001)); // R7 R17
  wire logic body_bad  = body_byte && eop && !zero_len && rem != 16'h0001; // R3

  // set element check on acknack and nackfrag bodies
  wire logic        frag = sub_id == `RMR_ID_NACK_FRAG;
  wire logic [31:0] sn_hi = get32(cap[8], cap[9], cap[10], cap[11], little);
  wire logic [31:0] sn_lo = get32(cap[12], cap[13], cap[14], cap[15],
                                  little);
  wire logic [31:0] w16 = get32(cap[16], cap[17], cap[18], cap[19], little);
  wire logic [31:0] w20 = get32(cap[20], cap[21], cap[22], cap[23], little);
  // fragment base is unsigned 32 bits, zero extended
  wire logic [63:0] set_base = frag ? {32'h0000_0000, w16}
                                    : {sn_hi, sn_lo}; // R11 R14
  wire logic [31:0] set_bits = frag ? w20 : w16;
  wire logic set_ok;
  wire logic set_unknown;
  wire logic has_set = sub_id == `RMR_ID_ACKNACK || frag;

  rmr_set_check u_set_check (
    .base         (set_base),
    .num_bits     (set_bits),
    .set_ok       (set_ok),
    .base_unknown (set_unknown)
  );

  // verdict on the submessage held in the stage
  wire logic long_enough = bcnt >= min_len(sub_id);
  wire logic sub_good = long_enough && (!has_set || set_ok);
  // no extensions are built in, so a known vendor's range is skipped too
  wire logic ignore = (vendor_kind && vendor_unk) ||
                      (vendor_kind && !vendor_unk) || !is_known; // R4 R5
  wire logic verdict_drop = p_end && !sop &&
                            (p_lenbad || (!ignore && !sub_good)); // R3 R8
  wire logic apply_info = p_end && !sop && !p_lenbad && !ignore &&
                          sub_good && is_info; // R9
  wire logic drop_now = hdr_short || (hdr_last && !hdr_ok) ||
                        subh_short || (sop && eop);

  // timestamp body: seconds then fraction
  wire logic [63:0] ts_now =
    {get32(cap[0], cap[1], cap[2], cap[3], little),
     get32(cap[4], cap[5], cap[6], cap[7], little)}; // R18

  // state machine
  rmr_pkg::rmr_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      rmr_pkg::RMR_IDLE: ;
      rmr_pkg::RMR_HDR: begin
        if (hdr_short)
          next_state = rmr_pkg::RMR_DROP; // R20
        else if (hdr_last)
          next_state = !hdr_ok ? rmr_pkg::RMR_DROP :
                       eop ? rmr_pkg::RMR_IDLE : rmr_pkg::RMR_SUBH;
      end
      rmr_pkg::RMR_SUBH: begin
        if (subh_short || empty_bad)
          next_state = rmr_pkg::RMR_DROP; // R2 R3
        else if (empty_end)
          next_state = rmr_pkg::RMR_IDLE;
        else if (subh_last)
          next_state = rmr_pkg::RMR_BODY;
      end
      rmr_pkg::RMR_BODY: begin
        if (body_end)
          next_state = eop ? rmr_pkg::RMR_IDLE : rmr_pkg::RMR_SUBH;
      end
      rmr_pkg::RMR_DROP: ;
    endcase
    if (verdict_drop && next_state != rmr_pkg::RMR_IDLE)
      next_state = rmr_pkg::RMR_DROP; // R8
    if (sop)
      next_state = eop ? rmr_pkg::RMR_IDLE : rmr_pkg::RMR_HDR; // R21
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      state <= rmr_pkg::RMR_IDLE;
    else
      state <= next_state;
  end

  // byte counters
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx      <= 5'h00;
      bcnt     <= 5'h00;
      rem      <= 16'h0000;
      zero_len <= 1'b0;
    end else if (sop) begin
      idx <= 5'h01;
    end else if ((st_hdr && v) || (st_subh && v && !subh_last)) begin
      idx <= hdr_last ? 5'h00 : idx + 5'h01;
    end else if (subh_last) begin
      idx      <= 5'h00;
      bcnt     <= 5'h00;
      rem      <= len_now; // R3 R7
      zero_len <= len_now == 16'h0000; // R17
    end else if (body_byte) begin
      rem <= rem - 16'h0001;
      if (bcnt != `RMR_CAP)
        bcnt <= bcnt + 5'h01;
    end
  end

  // capture of header bytes and the first body bytes
  always_ff @(posedge sys_clk) begin
    if (sop)
      cap[0] <= d;
    else if (st_hdr && v)
      cap[idx] <= d;
    else if (body_byte && bcnt != `RMR_CAP)
      cap[bcnt] <= d;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_id    <= 8'h00;
      sub_flags <= 8'h00;
      len_lo    <= 8'h00;
    end else if (st_subh && v && !sop) begin
      if (idx == 5'h00) sub_id <= d;
      if (idx == 5'h01) sub_flags <= d;
      if (idx == 5'h02) len_lo <= d;
    end
  end

  // verdict stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      p_fwd     <= 1'b0;
      p_first   <= 1'b0;
      p_end     <= 1'b0;
      p_lenbad  <= 1'b0;
      p_msg_end <= 1'b0;
      p_data    <= 8'h00;
    end else begin
      p_fwd     <= body_byte && is_entity && !vendor_kind; // R10
      p_first   <= bcnt == 5'h00;
      p_end     <= body_end || empty_end;
      p_lenbad  <= body_bad;
      p_msg_end <= eop && !sop;
      p_data    <= d;
    end
  end

  // receiver context
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctx.version    <= `RMR_VERSION_INIT;
      ctx.vendor     <= `RMR_VENDOR_UNK;
      ctx.src_prefix <= `RMR_PREFIX_UNK;
      ctx.dst_prefix <= `RMR_PREFIX_UNK;
      ctx.have_ts    <= 1'b0;
      ctx.ts         <= `RMR_TIME_INVALID;
      ctx.mc_loc     <= '0;
    end else if (sop) begin
      ctx.version        <= `RMR_VERSION_INIT;
      ctx.vendor         <= `RMR_VENDOR_UNK;
      ctx.src_prefix     <= `RMR_PREFIX_UNK;
      ctx.dst_prefix     <= local_prefix;
      ctx.have_ts        <= 1'b0; // R22
      ctx.ts             <= `RMR_TIME_INVALID; // R22
      ctx.mc_loc.kind    <= transport_kind; // R1
      ctx.mc_loc.addr    <= `RMR_ADDR_INVALID; // R1
      ctx.mc_loc.port    <= `RMR_PORT_INVALID; // R1
    end else if (hdr_last && hdr_ok) begin
      ctx.version    <= {cap[4], cap[5]}; // R19
      ctx.vendor     <= {cap[6], cap[7]}; // R19
      ctx.src_prefix <= {cap[8], cap[9], cap[10], cap[11], cap[12],
                         cap[13], cap[14], cap[15], cap[16], cap[17],
                         cap[18], d}; // R19
      ctx.have_ts    <= 1'b0; // R19
    end else if (apply_info) begin
      unique case (sub_id)
        `RMR_ID_INFO_TS: begin
          ctx.have_ts <= 1'b1;
          ctx.ts      <= ts_now;
        end
        `RMR_ID_INFO_SRC: begin
          ctx.version    <= {cap[4], cap[5]};
          ctx.vendor     <= {cap[6], cap[7]};
          ctx.src_prefix <= {cap[8], cap[9], cap[10], cap[11], cap[12],
                             cap[13], cap[14], cap[15], cap[16], cap[17],
                             cap[18], cap[19]};
        end
        `RMR_ID_INFO_DST:
          ctx.dst_prefix <= {cap[0], cap[1], cap[2], cap[3], cap[4],
                             cap[5], cap[6], cap[7], cap[8], cap[9],
                             cap[10], cap[11]};
        default: ;
      endcase
    end
  end

  // endpoint stream; the last byte carries the verdict
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ep_out   <= '0;
      msg_done <= 1'b0;
      msg_drop <= 1'b0;
      sub_skip <= 1'b0;
    end else begin
      ep_out.valid       <= p_fwd;
      ep_out.first       <= p_fwd && p_first;
      ep_out.last        <= p_fwd && p_end;
      ep_out.ok          <= p_fwd && p_end && !p_lenbad && sub_good; // R10
      ep_out.little      <= little;
      ep_out.set_unknown <= has_set && set_unknown; // R15
      ep_out.kind        <= sub_id;
      ep_out.data        <= p_data;
      msg_done <= (p_end && p_msg_end && !verdict_drop && !sop) ||
                  (hdr_last && hdr_ok && eop);
      msg_drop <= drop_now || empty_bad || verdict_drop; // R2 R3 R8
      sub_skip <= p_end && !p_lenbad && ignore && !sop; // R4 R5
    end
  end

endmodule

// File: tb/rmr_receiver_checker.sv
`include "rmr_defs.svh"

module rmr_receiver_checker (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              reset_n,
  // transport byte stream
  input wire rmr_pkg::rmr_in_t  in_byte,
  // local configuration
  input wire logic [31:0]       transport_kind,
  input wire logic [95:0]       local_prefix,
  // endpoint stream, context and events
  input wire rmr_pkg::rmr_ep_t  ep_out,
  input wire rmr_pkg::rmr_ctx_t ctx,
  input wire logic              msg_done,
  input wire logic              msg_drop,
  input wire logic              sub_skip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_SOP_LOCATOR: assert property (
    in_byte.valid && in_byte.sop |=> ctx.mc_loc == {$past(transport_kind),
      `RMR_ADDR_INVALID, `RMR_PORT_INVALID})
    else $error("reply locator not reset at message start");
  AST_SOP_TIME: assert property (
    in_byte.valid && in_byte.sop |=>
      !ctx.have_ts && ctx.ts == `RMR_TIME_INVALID)
    else $error("timestamp not cleared at message start");
  AST_TINY_DROP: assert property (
    in_byte.valid && in_byte.sop && in_byte.eop |=> msg_drop)
    else $error("one byte message not dropped");
  AST_EP_FOLLOWS: assert property (
    ep_out.valid |-> $past(in_byte.valid, 2) &&
      ep_out.data == $past(in_byte.data, 2))
    else $error("endpoint byte not the body byte two cycles back");
  AST_OK_ON_LAST: assert property (
    ep_out.ok |-> ep_out.valid && ep_out.last)
    else $error("ok outside the last endpoint byte");
  AST_DONE_DROP: assert property (
    !(msg_done && msg_drop))
    else $error("message both done and dropped");
  AST_DROP_QUIET: assert property (
    msg_drop |=> !ep_out.valid [*2])
    else $error("endpoint bytes after a drop");
  AST_CTX_HOLD: assert property (
    ep_out.valid && !$past(in_byte.sop) |-> $stable(ctx))
    else $error("context changed during an entity submessage");
  AST_SKIP_NO_EP: assert property (
    sub_skip |-> !ep_out.valid)
    else $error("skipped submessage reached the endpoint");
endmodule

bind rmr_receiver rmr_receiver_checker u_checker (
  .sys_clk        (sys_clk),
  .reset_n        (reset_n),
  .in_byte        (in_byte),
  .transport_kind (transport_kind),
  .local_prefix   (local_prefix),
  .ep_out         (ep_out),
  .ctx            (ctx),
  .msg_done       (msg_done),
  .msg_drop       (msg_drop),
  .sub_skip       (sub_skip)
);

// File: tb/rmr_transport.sv
module rmr_transport (
  // clock
  input wire logic         sys_clk,
  // byte stream toward the receiver
  output rmr_pkg::rmr_in_t in_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  initial in_byte = '0;

  // idle cycles show the inverse byte so stale data never looks fresh
  task automatic send(input logic [7:0] m[$], input int gap);
    for (int i = 0; i < m.size(); i++) begin
      @(negedge sys_clk);
      in_byte <= '{1'b1, i == 0, i == m.size() - 1, m[i]};
      repeat (gap) begin
        @(negedge sys_clk);
        in_byte <= '{1'b0, 1'b0, 1'b0, ~m[i]};
      end
    end
    @(negedge sys_clk);
    in_byte <= '{1'b0, 1'b0, 1'b0, ~m[m.size() - 1]};
  endtask
endmodule

// File: tb/rmr_receiver_tb.sv
`include "rmr_defs.svh"

module rmr_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // vendor value is arbitrary
  localparam logic [15:0] VEND = 16'h5aa5;
  localparam logic [95:0] SRC  = 96'h2021_2223_2425_2627_2829_2a2b;

  logic              sys_clk;
  logic              reset_n;
  rmr_pkg::rmr_in_t  in_byte;
  rmr_pkg::rmr_ep_t  ep_out;
  rmr_pkg::rmr_ctx_t ctx;
  logic              msg_done;
  logic              msg_drop;
  logic              sub_skip;
  logic [31:0]       kind_cfg   = 32'h0000_0001;
  logic [95:0]       prefix_cfg = 96'h0a0b_0c0d_0e0f_1011_1213_1415;
  int                miscompares;
  int                total_checks;
  int                n_done, n_drop, n_skip, n_ok, n_unk;
  logic [7:0]        msg[$];
  logic [7:0]        rx[$];
  logic [9:0]        fk[$];

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  rmr_transport tx (
    .sys_clk (sys_clk),
    .in_byte (in_byte)
  );

  rmr_receiver dut (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .in_byte        (in_byte),
    .transport_kind (kind_cfg),
    .local_prefix   (prefix_cfg),
    .ep_out         (ep_out),
    .ctx            (ctx),
    .msg_done       (msg_done),
    .msg_drop       (msg_drop),
    .sub_skip       (sub_skip)
  );

  // outputs stand one cycle; the falling edge sees them settled
  always @(negedge sys_clk) begin
    if (ep_out.valid === 1'b1) begin
      rx.push_back(ep_out.data);
      fk.push_back({ep_out.first, ep_out.little, ep_out.kind});
      n_ok += (ep_out.last & ep_out.ok) === 1'b1;
      n_unk += (ep_out.last & ep_out.set_unknown) === 1'b1;
    end
    n_done += msg_done === 1'b1;
    n_drop += msg_drop === 1'b1;
    n_skip += sub_skip === 1'b1;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic hdr(input logic [7:0] mark0, input logic [7:0] major);
    msg = {mark0, 8'h54, 8'h50, 8'h53, major, 8'h02, VEND[15:8], VEND[7:0]};
    for (int i = 0; i < 12; i++) msg.push_back(8'h20 + 8'(i));
  endtask

  task automatic sub(input logic [7:0] id, input logic [7:0] fl,
                     input logic [15:0] len, input int n,
                     input logic [7:0] b0);
    msg.push_back(id);
    msg.push_back(fl);
    msg.push_back(fl[0] ? len[7:0] : len[15:8]);
    msg.push_back(fl[0] ? len[15:8] : len[7:0]);
    for (int i = 0; i < n; i++) msg.push_back(b0 + 8'(i));
  endtask

  task automatic run(input int gap);
    n_done = 0;
    n_drop = 0;
    n_skip = 0;
    n_ok = 0;
    n_unk = 0;
    rx.delete();
    fk.delete();
    tx.send(msg, gap);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic ev(input int d, input int dr, input int s, input int e,
                    input int o);
    check(n_done, d);
    check(n_drop, dr);
    check(n_skip, s);
    check(rx.size(), e);
    check(n_ok, o);
  endtask

  task automatic t_data();
    hdr(8'h52, 8'h01);
    sub(`RMR_ID_DATA, 8'h01, 16'h0008, 8, 8'ha0);
    sub(`RMR_ID_NOKEY_DATA, 8'h80, 16'h0008, 8, 8'hb0);
    run(0);
    ev(1, 0, 0, 16, 2);
    check(rx[0], 8'ha0);
    check(rx[15], 8'hb7);
    check(fk[0], {1'b1, 1'b1, `RMR_ID_DATA});
    check(fk[8], {1'b1, 1'b0, `RMR_ID_NOKEY_DATA});
    check(ctx.dst_prefix, prefix_cfg);
    check(ctx.vendor, VEND);
    check(ctx.version, 16'h0102);
    check(ctx.src_prefix, SRC);
    check(ctx.mc_loc.kind, kind_cfg);
    check(ctx.mc_loc.addr, `RMR_ADDR_INVALID);
    check(ctx.mc_loc.port, `RMR_PORT_INVALID);
  endtask

  task automatic t_skip();
    hdr(8'h52, 8'h01);
    sub(8'h30, 8'h00, 16'h0004, 4, 8'h00);
    sub(8'h80, 8'h01, 16'h0004, 4, 8'h00);
    sub(`RMR_ID_DATA, 8'h01, 16'h0000, 8, 8'hc0);
    run(2);
    ev(1, 0, 2, 8, 1);
    check(rx[7], 8'hc7);
  endtask

  task automatic t_ts();
    hdr(8'h52, 8'h01);
    sub(`RMR_ID_INFO_TS, 8'h01, 16'h0008, 8, 8'h40);
    sub(`RMR_ID_INFO_DST, 8'h00, 16'h000c, 12, 8'h60);
    sub(`RMR_ID_DATA, 8'h00, 16'h0008, 8, 8'h00);
    run(0);
    ev(1, 0, 0, 8, 1);
    check(ctx.have_ts, 1'b1);
    check(ctx.ts, 64'h4342_4140_4746_4544);
    check(ctx.dst_prefix, 96'h6061_6263_6465_6667_6869_6a6b);
  endtask

  // wrong marker, too high major, then a one byte message
  task automatic t_bad();
    for (int k = 0; k < 3; k++) begin
      hdr(k == 0 ? 8'h51 : 8'h52, k == 1 ? 8'h02 : 8'h01);
      if (k == 2) begin
        msg = {8'h52};
      end else begin
        sub(`RMR_ID_DATA, 8'h01, 16'h0008, 8, 8'h00);
      end
      run(0);
      ev(0, 1, 0, 0, 0);
      check(ctx.have_ts, 1'b0);
      check(ctx.ts, `RMR_TIME_INVALID);
    end
  endtask

  task automatic t_trunc();
    hdr(8'h52, 8'h01);
    msg.push_back(`RMR_ID_DATA);
    msg.push_back(8'h01);
    run(0);
    ev(0, 1, 0, 0, 0);
    hdr(8'h52, 8'h01);
    sub(`RMR_ID_DATA, 8'h01, 16'h0008, 4, 8'h00);
    run(0);
    ev(0, 1, 0, 4, 0);
  endtask

  // bytes 8..23 of the body: base, bit count, bitmap or fragment fields
  task automatic t_set();
    logic [127:0] w [6];
    logic [7:0]   id;
    w = '{{64'h1, 32'h100, 32'h0}, {64'h0, 32'h1, 32'h0},
          {64'h1, 32'h101, 32'h0}, {`RMR_SN_UNKNOWN, 32'h1, 32'h0},
          {64'h1_0000_0000, 32'h1, 32'h0},
          {64'h0, 32'h8000_0000, 32'h100}};
    for (int k = 0; k < 6; k++) begin
      id = (k == 5) ? `RMR_ID_NACK_FRAG : `RMR_ID_ACKNACK;
      hdr(8'h52, 8'h01);
      sub(id, 8'h00, 16'h0018, 8, 8'h00);
      for (int i = 15; i >= 0; i--) msg.push_back(w[k][8*i +: 8]);
      sub(`RMR_ID_DATA, 8'h01, 16'h0008, 8, 8'hd0);
      run(0);
      if (k == 0 || k >= 4) begin
        ev(1, 0, 0, 32, 2);
      end else begin
        ev(0, 1, 0, 24, 0);
      end
      check(n_unk, k == 3);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(ctx.ts, `RMR_TIME_INVALID);
    reset_n = 1'b1;
    t_data();
    t_skip();
    t_ts();
    t_bad();
    t_trunc();
    t_set();
    conclude();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #200_000;
    miscompares++;
    conclude();
  end
endmodule
